// ---- led_matrix_shutdown_detect_ctrl_tb.sv ----
// Self-checking testbench joining controller and device ends
`timescale 1ns/1ns
`default_nettype none
module led_matrix_shutdown_detect_ctrl_tb;
   logic clk, rst, read, write, waitrequest, scanCycleEnd;
   logic [3:0] address, scanCnt;
   logic [31:0] writedata, readdata;
   logic [7:0] rowDriving, rowPullOn, globalCurrentLevel;
   logic [17:0] colDriving, colPullOn;
   logic [143:0] ledScaledOff, openSense, shortSense;
   logic analogOn, sinksOn, detectBusy;
   logic [3:0] rowPullStrength, colPullStrength;
   int fail_count = 0;
   int cmp_count = 0;
   int cycles = 0;
   lmsdc_link_if link();
   lmsdc_host i_lmsdc_host (.clk(clk), .rst(rst), .link(link), .address(address), .read(read), .write(write),
      .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest));
   lmsdc_device i_lmsdc_device (.clk(clk), .rst(rst), .link(link), .scanCycleEnd(scanCycleEnd),
      .rowDriving(rowDriving), .colDriving(colDriving), .ledScaledOff(ledScaledOff), .openSense(openSense),
      .shortSense(shortSense), .analogOn(analogOn), .sinksOn(sinksOn), .globalCurrentLevel(globalCurrentLevel),
      .rowPullStrength(rowPullStrength), .colPullStrength(colPullStrength), .rowPullOn(rowPullOn),
      .colPullOn(colPullOn), .detectBusy(detectBusy));
   lmsdc_link_monitor i_lmsdc_link_monitor (.clk(clk), .rst(rst), .shutdownPinN(link.shutdownPinN),
      .reqValid(link.reqValid), .reqWrite(link.reqWrite), .reqAddr(link.reqAddr), .reqWdata(link.reqWdata),
      .respValid(link.respValid), .analogOn(analogOn), .sinksOn(sinksOn), .detectBusy(detectBusy),
      .rowDriving(rowDriving), .colDriving(colDriving), .rowPullOn(rowPullOn), .colPullOn(colPullOn));
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   // Scan cycle ends every 16 clocks
   always @(posedge clk) begin
      scanCnt <= scanCnt + 4'h1;
      scanCycleEnd <= (scanCnt == 4'hF);
      cycles++;
      if (cycles == 20000) begin
         fail_count++;
         results();
      end
   end
   task automatic results();
      $display("Comparisons %0d, mismatches %0d", cmp_count, fail_count);
      if (fail_count == 0 && cmp_count > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         fail_count++;
         $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic av(input logic [3:0] a, input logic wr, input logic [31:0] d, output logic [31:0] q);
      int n;
      n = 0;
      @(posedge clk);
      address <= a;
      read <= !wr;
      write <= wr;
      writedata <= d;
      do begin
         @(posedge clk);
         n++;
      end while (waitrequest !== 1'b0 && n < 200);
      q = readdata;
      read <= 1'b0;
      write <= 1'b0;
      check("avalon answer", n < 200, 1);
   endtask
   // Queue one device access, then poll busy; result byte from status
   task automatic dev(input logic [7:0] a, input logic wr, input logic [7:0] d, output logic [7:0] q);
      logic [31:0] st;
      av(lmsdc_pkg::AV_COMMAND, 1'b1, {15'h0000, !wr, a, d}, st);
      for (int i = 0; i < 50; i++) begin
         av(lmsdc_pkg::AV_STATUS, 1'b0, 32'h0, st);
         if (st[lmsdc_pkg::ST_BUSY_BIT] === 1'b0)
            break;
      end
      check("link idle", st[lmsdc_pkg::ST_BUSY_BIT], 0);
      q = st[15:8];
   endtask
   task automatic t_reset();
      logic [31:0] q;
      logic [7:0] b;
      av(lmsdc_pkg::AV_STATUS, 1'b0, 32'h0, q);
      check("pin status", q[lmsdc_pkg::ST_PIN_BIT], 0);
      check("analog off", analogOn, 0);
      av(4'hC, 1'b1, 32'hFFFFFFFF, q);
      av(4'hC, 1'b0, 32'h0, q);
      check("unmapped read", q, 0);
      for (int a = 0; a < 3; a++) begin
         dev(a[7:0], 1'b0, 8'h00, b);
         check("reg reset", b, lmsdc_pkg::REG_RESET_VALUE);
      end
   endtask
   task automatic t_hw_shutdown();
      logic [31:0] q;
      logic [7:0] b;
      dev(lmsdc_pkg::REG_GLOBAL_CURRENT, 1'b1, 8'h20, b);
      dev(lmsdc_pkg::REG_GLOBAL_CURRENT, 1'b0, 8'h00, b);
      check("current in hw shutdown", b, 8'h20);
      check("current output", globalCurrentLevel, 8'h20);
      av(lmsdc_pkg::AV_PIN, 1'b1, 32'h1, q); // pulls still off here
      repeat (6) @(posedge clk); // link kept quiet across the rise
      check("analog on", analogOn, 1);
      dev(lmsdc_pkg::REG_GLOBAL_CURRENT, 1'b0, 8'h00, b);
      check("current kept", b, 8'h20);
   endtask
   task automatic t_soft_shutdown();
      logic [31:0] q;
      logic [7:0] b;
      dev(lmsdc_pkg::REG_CONFIG, 1'b1, 8'h01, b);
      repeat (2) @(posedge clk);
      check("sinks running", sinksOn, 1);
      dev(lmsdc_pkg::REG_CONFIG, 1'b1, 8'h00, b);
      repeat (2) @(posedge clk);
      check("sinks blank", sinksOn, 0);
      rowDriving <= 8'hF0;
      colDriving <= 18'h0000F;
      dev(lmsdc_pkg::REG_PULL_SELECT, 1'b1, 8'h21, b);
      dev(lmsdc_pkg::REG_PULL_SELECT, 1'b0, 8'h00, b);
      check("pulls in soft shutdown", b, 8'h21);
      check("row strength", rowPullStrength, 4'h1);
      check("col strength", colPullStrength, 4'h2);
      check("row pulls", rowPullOn, 8'h0F);
      check("col pulls", colPullOn, 18'h3FFF0);
      dev(lmsdc_pkg::REG_CONFIG, 1'b1, 8'h01, b);
      repeat (2) @(posedge clk);
      check("sinks before pin drop", sinksOn, 1);
      // Deliberately drops the pin with pulls on, expecting a warning
      av(lmsdc_pkg::AV_PIN, 1'b1, 32'h0, q);
      repeat (6) @(posedge clk);
      av(lmsdc_pkg::AV_STATUS, 1'b0, 32'h0, q);
      check("pull warning", q[lmsdc_pkg::ST_WARN_PULL_BIT], 1);
      check("sinks in hw shutdown", sinksOn, 0);
      dev(lmsdc_pkg::REG_GLOBAL_CURRENT, 1'b1, 8'h20, b);
      dev(lmsdc_pkg::REG_PULL_SELECT, 1'b1, 8'h00, b);
      av(lmsdc_pkg::AV_STATUS, 1'b1, 32'h4, q);
      av(lmsdc_pkg::AV_PIN, 1'b1, 32'h1, q);
      repeat (6) @(posedge clk);
      av(lmsdc_pkg::AV_STATUS, 1'b0, 32'h0, q);
      check("warning cleared", q[lmsdc_pkg::ST_WARN_PULL_BIT], 0);
      dev(lmsdc_pkg::REG_PULL_SELECT, 1'b0, 8'h00, b);
      check("pulls kept off", b, 8'h00);
   endtask
   task automatic expect_byte(input logic [7:0] a, input logic [7:0] e);
      logic [7:0] b;
      dev(a, 1'b0, 8'h00, b);
      check("result byte", b, e);
   endtask
   task automatic t_detect();
      logic [7:0] b;
      logic [31:0] q;
      // Current 20h and pulls 00h already set beforehand
      openSense <= '1;
      ledScaledOff <= 144'hFF;
      dev(lmsdc_pkg::REG_CONFIG, 1'b1, 8'h03, b);
      check("detect running", detectBusy, 1);
      repeat (40) @(posedge clk);
      check("detect done", detectBusy, 0);
      av(lmsdc_pkg::AV_STATUS, 1'b0, 32'h0, q);
      check("no detect warning", q[lmsdc_pkg::ST_WARN_DETECT_BIT], 0);
      expect_byte(8'h03, 8'h00);
      expect_byte(8'h04, 8'hFF);
      expect_byte(lmsdc_pkg::REG_RESULT_LAST, 8'h00);
      openSense <= '0;
      dev(lmsdc_pkg::REG_CONFIG, 1'b1, 8'h03, b);
      repeat (40) @(posedge clk);
      expect_byte(8'h04, 8'hFF);
      shortSense <= '1;
      dev(lmsdc_pkg::REG_CONFIG, 1'b1, 8'h01, b);
      dev(lmsdc_pkg::REG_CONFIG, 1'b1, 8'h05, b);
      repeat (40) @(posedge clk);
      expect_byte(8'h05, 8'hFF);
      expect_byte(8'h03, 8'h00);
      dev(lmsdc_pkg::REG_CONFIG, 1'b1, 8'h01, b);
      dev(lmsdc_pkg::REG_CONFIG, 1'b1, 8'h03, b);
      repeat (40) @(posedge clk);
      expect_byte(8'h04, 8'h00);
      dev(lmsdc_pkg::REG_CONFIG, 1'b1, 8'h01, b);
      // Current below the floor on purpose, so the host must flag the trigger
      dev(lmsdc_pkg::REG_GLOBAL_CURRENT, 1'b1, 8'h05, b);
      dev(lmsdc_pkg::REG_CONFIG, 1'b1, 8'h03, b);
      av(lmsdc_pkg::AV_STATUS, 1'b0, 32'h0, q);
      check("detect warning", q[lmsdc_pkg::ST_WARN_DETECT_BIT], 1);
   endtask
   initial begin
      rst = 1'b1;
      address = 4'h0;
      read = 1'b0;
      write = 1'b0;
      writedata = 32'h0;
      scanCnt = 4'h0;
      scanCycleEnd = 1'b0;
      rowDriving = '0;
      colDriving = '0;
      ledScaledOff = '0;
      openSense = '0;
      shortSense = '0;
      repeat (6) @(posedge clk);
      rst <= 1'b0;
      t_reset();
      t_hw_shutdown();
      t_soft_shutdown();
      t_detect();
      results();
   end
endmodule // led_matrix_shutdown_detect_ctrl_tb
`default_nettype wire

// ---- lmsdc_device.sv ----
// Device end: shutdown, register link, open/short detect and anti-ghost pulls
`timescale 1ns/1ns
`default_nettype none
module lmsdc_device (
   input wire logic clk,
   input wire logic rst,
   lmsdc_link_if.device link,
   input wire logic scanCycleEnd,
   input wire logic [lmsdc_pkg::ROWS-1:0] rowDriving,
   input wire logic [lmsdc_pkg::COLS-1:0] colDriving,
   input wire logic [lmsdc_pkg::LEDS-1:0] ledScaledOff,
   input wire logic [lmsdc_pkg::LEDS-1:0] openSense,
   input wire logic [lmsdc_pkg::LEDS-1:0] shortSense,
   output logic analogOn,
   output logic sinksOn,
   output logic [7:0] globalCurrentLevel,
   output logic [3:0] rowPullStrength,
   output logic [3:0] colPullStrength,
   output logic [lmsdc_pkg::ROWS-1:0] rowPullOn,
   output logic [lmsdc_pkg::COLS-1:0] colPullOn,
   output logic detectBusy
);
   logic pinLevel;
   logic pinRise;
   logic [7:0] configReg;
   logic [7:0] globalCurrentReg;
   logic [7:0] pullSelect;
   logic [lmsdc_pkg::LEDS-1:0] faultBits;
   logic [1:0] prevDetect;
   logic [1:0] scanCount;
   lmsdc_pkg::lmsdc_det_t detState;
   logic [1:0] detectField;
   logic softRun;
   logic linkWrite;

   // Results read from the fault array, zero past its end
   function automatic logic [7:0] resultByte(input logic [7:0] addr,
                                             input logic [lmsdc_pkg::LEDS-1:0] bits);
      logic [7:0] idx;
      resultByte = 8'h00;
      idx = addr - lmsdc_pkg::REG_RESULT_FIRST;
      if (idx < 8'(lmsdc_pkg::RESULT_BYTES)) begin
         resultByte = bits[idx*8 +: 8];
      end
   endfunction

   function automatic logic [7:0] readReg(input logic [7:0] addr, input logic [7:0] cfg,
                                          input logic [7:0] gcl, input logic [7:0] pul,
                                          input logic [lmsdc_pkg::LEDS-1:0] bits);
      readReg = 8'h00;
      if (addr == lmsdc_pkg::REG_CONFIG) begin
         readReg = cfg;
      end else if (addr == lmsdc_pkg::REG_GLOBAL_CURRENT) begin
         readReg = gcl;
      end else if (addr == lmsdc_pkg::REG_PULL_SELECT) begin
         readReg = pul;
      end else if (addr >= lmsdc_pkg::REG_RESULT_FIRST && addr <= lmsdc_pkg::REG_RESULT_LAST) begin
         readReg = resultByte(addr, bits);
      end
   endfunction

   lmsdc_pin_sync pinSync (
      .clk(clk),
      .rst(rst),
      .pinIn(link.shutdownPinN),
      .level(pinLevel),
      .rise(pinRise)
   );

   assign detectField = configReg[lmsdc_pkg::CFG_DETECT_LSB +: 2];
   assign softRun = configReg[lmsdc_pkg::CFG_SOFT_RUN_BIT];
   // Accepted only when idle so a request is served exactly once
   assign linkWrite = link.reqValid & link.reqWrite & ~link.respValid & ~pinRise;

   // Link answers one cycle after a request, whatever the shutdown state, except that a pin-rise cycle drops the answer
   always_ff @(posedge clk) begin
      if (rst) begin
         link.respValid <= 1'b0;
         link.respRdata <= 8'h00;
      end else if (pinRise) begin
         link.respValid <= 1'b0;
         link.respRdata <= 8'h00;
      end else if (link.reqValid & ~link.respValid) begin
         link.respValid <= 1'b1;
         link.respRdata <= readReg(link.reqAddr, configReg, globalCurrentReg, pullSelect, faultBits);
      end else begin
         link.respValid <= 1'b0;
      end
   end

   // Registers change only by link writes or reset, never by shutdown
   always_ff @(posedge clk) begin
      if (rst) begin
         configReg <= lmsdc_pkg::REG_RESET_VALUE;
         globalCurrentReg <= lmsdc_pkg::REG_RESET_VALUE;
         pullSelect <= lmsdc_pkg::REG_RESET_VALUE;
      end else if (linkWrite) begin
         if (link.reqAddr == lmsdc_pkg::REG_CONFIG) begin
            configReg <= link.reqWdata;
         end
         if (link.reqAddr == lmsdc_pkg::REG_GLOBAL_CURRENT) begin
            globalCurrentReg <= link.reqWdata;
         end
         if (link.reqAddr == lmsdc_pkg::REG_PULL_SELECT) begin
            pullSelect <= link.reqWdata;
         end
      end
   end

   // One-shot detection; DONE holds until the field returns to off
   always_ff @(posedge clk) begin
      if (rst) begin
         detState <= lmsdc_pkg::DET_IDLE;
         prevDetect <= lmsdc_pkg::DETECT_OFF;
         scanCount <= 2'h0;
      end else begin
         prevDetect <= detectField;
         case (detState)
            lmsdc_pkg::DET_IDLE: begin
               scanCount <= 2'h0;
               if (prevDetect == lmsdc_pkg::DETECT_OFF &&
                   (detectField == lmsdc_pkg::DETECT_OPEN || detectField == lmsdc_pkg::DETECT_SHORT)) begin
                  detState <= lmsdc_pkg::DET_RUN;
               end
            end
            lmsdc_pkg::DET_RUN: begin
               if (detectField == lmsdc_pkg::DETECT_OFF) begin
                  detState <= lmsdc_pkg::DET_IDLE;
               end else if (scanCycleEnd) begin
                  scanCount <= scanCount + 2'h1;
                  if (scanCount + 2'h1 == lmsdc_pkg::SCAN_CYCLES_MIN) begin
                     detState <= lmsdc_pkg::DET_DONE;
                  end
               end
            end
            lmsdc_pkg::DET_DONE: begin
               if (detectField == lmsdc_pkg::DETECT_OFF) begin
                  detState <= lmsdc_pkg::DET_IDLE;
               end
            end
            default: begin
               detState <= lmsdc_pkg::DET_IDLE;
            end
         endcase
      end
   end

   // Capture at the closing scan edge, per LED
   genvar led;
   generate
      for (led = 0; led < lmsdc_pkg::LEDS; led++) begin : gCapture
         always_ff @(posedge clk) begin
            if (rst) begin
               faultBits[led] <= 1'b0;
            end else if (detState == lmsdc_pkg::DET_RUN && scanCycleEnd &&
                         detectField != lmsdc_pkg::DETECT_OFF &&
                         scanCount + 2'h1 == lmsdc_pkg::SCAN_CYCLES_MIN && !ledScaledOff[led]) begin
               faultBits[led] <= (detectField == lmsdc_pkg::DETECT_OPEN) ? openSense[led] : shortSense[led];
            end
         end
      end
   endgenerate

   always_ff @(posedge clk) begin
      if (rst) begin
         detectBusy <= 1'b0;
      end else begin
         detectBusy <= (detState == lmsdc_pkg::DET_RUN);
      end
   end

   // Power state: pin low stops analog, soft-run low blanks sinks
   always_ff @(posedge clk) begin
      if (rst) begin
         analogOn <= 1'b0;
         sinksOn <= 1'b0;
         globalCurrentLevel <= lmsdc_pkg::REG_RESET_VALUE;
      end else begin
         analogOn <= pinLevel;
         sinksOn <= pinLevel & softRun;
         globalCurrentLevel <= globalCurrentReg;
      end
   end

   // Pulls follow the select register and only touch idle lines
   always_ff @(posedge clk) begin
      if (rst) begin
         rowPullStrength <= lmsdc_pkg::PULL_OFF;
         colPullStrength <= lmsdc_pkg::PULL_OFF;
      end else begin
         rowPullStrength <= pullSelect[lmsdc_pkg::PULL_ROW_LSB +: 4];
         colPullStrength <= pullSelect[lmsdc_pkg::PULL_COL_LSB +: 4];
      end
   end

   genvar r;
   generate
      for (r = 0; r < lmsdc_pkg::ROWS; r++) begin : gRowPull
         always_ff @(posedge clk) begin
            if (rst) begin
               rowPullOn[r] <= 1'b0;
            end else begin
               // Analog off means no pull current either
               rowPullOn[r] <= pinLevel && !rowDriving[r] &&
                               pullSelect[lmsdc_pkg::PULL_ROW_LSB +: 4] != lmsdc_pkg::PULL_OFF;
            end
         end
      end
   endgenerate

   genvar c;
   generate
      for (c = 0; c < lmsdc_pkg::COLS; c++) begin : gColPull
         always_ff @(posedge clk) begin
            if (rst) begin
               colPullOn[c] <= 1'b0;
            end else begin
               colPullOn[c] <= pinLevel && !colDriving[c] &&
                               pullSelect[lmsdc_pkg::PULL_COL_LSB +: 4] != lmsdc_pkg::PULL_OFF;
            end
         end
      end
   endgenerate
endmodule // lmsdc_device
`default_nettype wire

// ---- lmsdc_host.sv ----
// Controller end: Avalon-MM slave driving the register link and shutdown pin
`timescale 1ns/1ns
`default_nettype none
module lmsdc_host (
   input wire logic clk,
   input wire logic rst,
   lmsdc_link_if.host link,
   input wire logic [3:0] address,
   input wire logic read,
   input wire logic write,
   input wire logic [31:0] writedata,
   output logic [31:0] readdata,
   output logic waitrequest
);
   logic busy;
   logic pinLevel;
   logic [7:0] lastRdata;
   logic pullsOn;
   logic [7:0] currentShadow;
   logic warnPull;
   logic warnDetect;
   logic accept;
   logic commit;
   logic cmdWrite;
   logic pinWrite;
   logic setWarnPull;
   logic setWarnDetect;
   logic clrWarn;
   logic [7:0] cmdAddr;
   logic [7:0] cmdData;

   // Link and pin orders wait while a link transfer is open
   assign accept = (read | write) & waitrequest &
                   ~(write & busy & (address == lmsdc_pkg::AV_COMMAND || address == lmsdc_pkg::AV_PIN));
   assign commit = write & ~waitrequest;
   assign cmdAddr = writedata[lmsdc_pkg::CMD_ADDR_LSB +: 8];
   assign cmdData = writedata[7:0];
   assign cmdWrite = commit & (address == lmsdc_pkg::AV_COMMAND);
   assign pinWrite = commit & (address == lmsdc_pkg::AV_PIN);
   assign clrWarn = commit & (address == lmsdc_pkg::AV_STATUS);
   assign setWarnPull = pinWrite & ~writedata[0] & pinLevel & pullsOn;
   assign setWarnDetect = cmdWrite & ~writedata[lmsdc_pkg::CMD_READ_BIT] & (cmdAddr == lmsdc_pkg::REG_CONFIG) &
                          (cmdData[lmsdc_pkg::CFG_DETECT_LSB +: 2] != lmsdc_pkg::DETECT_OFF) &
                          (pullsOn | currentShadow < lmsdc_pkg::CURRENT_MIN |
                           currentShadow > lmsdc_pkg::CURRENT_MAX);

   always_ff @(posedge clk) begin
      if (rst) begin
         waitrequest <= 1'b1;
         readdata <= 32'h00000000;
      end else begin
         waitrequest <= ~accept;
         if (accept && read) begin
            readdata <= 32'h00000000;
            if (address == lmsdc_pkg::AV_STATUS) begin
               readdata[lmsdc_pkg::ST_BUSY_BIT] <= busy;
               readdata[lmsdc_pkg::ST_PIN_BIT] <= pinLevel;
               readdata[lmsdc_pkg::ST_WARN_PULL_BIT] <= warnPull;
               readdata[lmsdc_pkg::ST_WARN_DETECT_BIT] <= warnDetect;
               readdata[lmsdc_pkg::ST_RDATA_LSB +: 8] <= lastRdata;
            end else if (address == lmsdc_pkg::AV_PIN) begin
               readdata[0] <= pinLevel;
            end
         end
      end
   end

   // Request held on the link until the device answers
   always_ff @(posedge clk) begin
      if (rst) begin
         busy <= 1'b0;
         link.reqValid <= 1'b0;
         link.reqWrite <= 1'b0;
         link.reqAddr <= 8'h00;
         link.reqWdata <= 8'h00;
         lastRdata <= 8'h00;
      end else if (cmdWrite) begin
         busy <= 1'b1;
         link.reqValid <= 1'b1;
         link.reqWrite <= ~writedata[lmsdc_pkg::CMD_READ_BIT];
         link.reqAddr <= cmdAddr;
         link.reqWdata <= cmdData;
      end else if (busy && link.respValid) begin
         busy <= 1'b0;
         link.reqValid <= 1'b0;
         lastRdata <= link.respRdata;
      end
   end

   // Pin starts low: device held in hardware shutdown until software raises it
   always_ff @(posedge clk) begin
      if (rst) begin
         pinLevel <= 1'b0;
         link.shutdownPinN <= 1'b0;
      end else if (pinWrite) begin
         pinLevel <= writedata[0];
         link.shutdownPinN <= writedata[0];
      end
   end

   // Shadows of what was sent, for the order checks
   always_ff @(posedge clk) begin
      if (rst) begin
         pullsOn <= 1'b0;
         currentShadow <= lmsdc_pkg::REG_RESET_VALUE;
      end else if (cmdWrite && !writedata[lmsdc_pkg::CMD_READ_BIT]) begin
         if (cmdAddr == lmsdc_pkg::REG_PULL_SELECT) begin
            pullsOn <= (cmdData != 8'h00);
         end
         if (cmdAddr == lmsdc_pkg::REG_GLOBAL_CURRENT) begin
            currentShadow <= cmdData;
         end
      end
   end

   // Sticky warnings; a new event beats a clear in the same cycle
   always_ff @(posedge clk) begin
      if (rst) begin
         warnPull <= 1'b0;
         warnDetect <= 1'b0;
      end else begin
         warnPull <= setWarnPull | (warnPull & ~(clrWarn & writedata[lmsdc_pkg::ST_WARN_PULL_BIT]));
         warnDetect <= setWarnDetect | (warnDetect & ~(clrWarn & writedata[lmsdc_pkg::ST_WARN_DETECT_BIT]));
      end
   end
endmodule // lmsdc_host
`default_nettype wire

// ---- lmsdc_link_if.sv ----
// Register link and shutdown pin between controller and device
`timescale 1ns/1ns
`default_nettype none
interface lmsdc_link_if;
   logic shutdownPinN;
   logic reqValid;
   logic reqWrite;
   logic [7:0] reqAddr;
   logic [7:0] reqWdata;
   logic respValid;
   logic [7:0] respRdata;
   modport device (input shutdownPinN, input reqValid, input reqWrite, input reqAddr, input reqWdata,
                   output respValid, output respRdata);
   modport host (output shutdownPinN, output reqValid, output reqWrite, output reqAddr, output reqWdata,
                 input respValid, input respRdata);
endinterface
`default_nettype wire

// ---- lmsdc_link_monitor.sv ----
// Assertion checker beside the controller-device link
`timescale 1ns/1ns
`default_nettype none
module lmsdc_link_monitor (
   input wire logic clk,
   input wire logic rst,
   input wire logic shutdownPinN,
   input wire logic reqValid,
   input wire logic reqWrite,
   input wire logic [7:0] reqAddr,
   input wire logic [7:0] reqWdata,
   input wire logic respValid,
   input wire logic analogOn,
   input wire logic sinksOn,
   input wire logic detectBusy,
   input wire logic [lmsdc_pkg::ROWS-1:0] rowDriving,
   input wire logic [lmsdc_pkg::COLS-1:0] colDriving,
   input wire logic [lmsdc_pkg::ROWS-1:0] rowPullOn,
   input wire logic [lmsdc_pkg::COLS-1:0] colPullOn
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   logic [1:0] settle;
   // Pin history before reset is meaningless for the latency check
   always_ff @(posedge clk) begin
      if (rst)
         settle <= 2'h0;
      else if (settle != 2'h3)
         settle <= settle + 2'h1;
   end
   sequence s_req_taken;
      reqValid && !respValid;
   endsequence
   sequence s_cfg_blank;
      respValid && reqWrite && reqAddr == lmsdc_pkg::REG_CONFIG && !reqWdata[lmsdc_pkg::CFG_SOFT_RUN_BIT];
   endsequence
   chk_resp_one_pulse: assert property (s_req_taken |=> respValid ##1 !respValid)
      else $error("respValid not a single pulse after a request");
   chk_resp_needs_req: assert property (respValid |-> $past(reqValid))
      else $error("respValid without a pending request");
   // Two sync stages, the level flop and the output flop: four edges from pin to analogOn
   chk_analog_follows_pin: assert property (settle == 2'h3 |-> analogOn == $past(shutdownPinN, 4))
      else $error("analogOn does not follow the synchronised pin");
   chk_sinks_need_pin: assert property (sinksOn |-> $past(shutdownPinN, 4))
      else $error("sinks on during hardware shutdown");
   chk_soft_blank: assert property (s_cfg_blank |=> !sinksOn)
      else $error("sinks still on after soft-run cleared");
   chk_row_pull_idle: assert property ((rowPullOn & $past(rowDriving)) == '0)
      else $error("row pull on a driving row");
   chk_col_pull_idle: assert property ((colPullOn & $past(colDriving)) == '0)
      else $error("column pull on a driving column");
   chk_link_reset_rise: assert property ($rose(analogOn) |-> !respValid)
      else $error("link answer survives the pin rise");
   chk_detect_bounded: assert property ($rose(detectBusy) |-> ##[1:100] !detectBusy)
      else $error("detection pass does not finish");
endmodule // lmsdc_link_monitor
`default_nettype wire

// ---- lmsdc_pin_sync.sv ----
// Two-stage pin synchroniser with rising-edge pulse
`timescale 1ns/1ns
`default_nettype none
module lmsdc_pin_sync (
   input wire logic clk,
   input wire logic rst,
   input wire logic pinIn,
   output logic level,
   output logic rise
);
   logic stage1;
   logic stage2;
   always_ff @(posedge clk) begin
      if (rst) begin
         stage1 <= 1'b0;
         stage2 <= 1'b0;
      end else begin
         stage1 <= pinIn;
         stage2 <= stage1;
      end
   end
   always_ff @(posedge clk) begin
      if (rst) begin
         level <= 1'b0;
         rise <= 1'b0;
      end else begin
         level <= stage2;
         rise <= stage2 & ~level;
      end
   end
endmodule // lmsdc_pin_sync
`default_nettype wire

// ---- lmsdc_pkg.sv ----
// Shared constants of the LED matrix shutdown and detect control block
package lmsdc_pkg;
   localparam int unsigned ROWS = 8;
   localparam int unsigned COLS = 18;
   localparam int unsigned LEDS = ROWS * COLS;
   localparam int unsigned RESULT_BYTES = LEDS / 8;
   // Device register map (configuration page)
   localparam logic [7:0] REG_CONFIG = 8'h00;
   localparam logic [7:0] REG_GLOBAL_CURRENT = 8'h01;
   localparam logic [7:0] REG_PULL_SELECT = 8'h02;
   localparam logic [7:0] REG_RESULT_FIRST = 8'h03;
   localparam logic [7:0] REG_RESULT_LAST = 8'h1A;
   // Configuration fields
   localparam int unsigned CFG_SOFT_RUN_BIT = 0;
   localparam int unsigned CFG_DETECT_LSB = 1;
   localparam logic [1:0] DETECT_OFF = 2'h0;
   localparam logic [1:0] DETECT_OPEN = 2'h1;
   localparam logic [1:0] DETECT_SHORT = 2'h2;
   // Pull select fields: row strength low nibble, column strength high nibble
   localparam int unsigned PULL_ROW_LSB = 0;
   localparam int unsigned PULL_COL_LSB = 4;
   localparam logic [3:0] PULL_OFF = 4'h0;
   localparam logic [7:0] REG_RESET_VALUE = 8'h00;
   localparam logic [7:0] CURRENT_MIN = 8'h0F;
   localparam logic [7:0] CURRENT_MAX = 8'h40;
   localparam logic [1:0] SCAN_CYCLES_MIN = 2'h2;
   // Controller Avalon-MM map (byte addresses)
   localparam logic [3:0] AV_COMMAND = 4'h0;
   localparam logic [3:0] AV_STATUS = 4'h4;
   localparam logic [3:0] AV_PIN = 4'h8;
   localparam int unsigned CMD_ADDR_LSB = 8;
   localparam int unsigned CMD_READ_BIT = 16;
   localparam int unsigned ST_BUSY_BIT = 0;
   localparam int unsigned ST_PIN_BIT = 1;
   localparam int unsigned ST_WARN_PULL_BIT = 2;
   localparam int unsigned ST_WARN_DETECT_BIT = 3;
   localparam int unsigned ST_RDATA_LSB = 8;
   typedef enum logic [1:0] {
      DET_IDLE = 2'b00,
      DET_RUN = 2'b01,
      DET_DONE = 2'b10
   } lmsdc_det_t;
endpackage
